// ### rtl/asp_pkg.sv
package asp_pkg;
   // ****************************************************************
   // clock and wake timing
   // ****************************************************************
   localparam int CLK_MHZ = 100;
   localparam int POWER_UP_WAIT_NS = 1000; // power_up_wait after full shutdown
   localparam int WAKE_NS = 1000; // wake-up from autoshutdown or standby
   localparam logic [7:0] POWER_UP_WAIT_CYC = 8'((POWER_UP_WAIT_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0] WAKE_CYC = 8'((WAKE_NS * CLK_MHZ + 999) / 1000);

   // ****************************************************************
   // frame edge counts
   // ****************************************************************
   localparam logic [4:0] CFG_BITS = 5'h0c;
   localparam logic [4:0] TRACK_EDGE = 5'h0e;
   localparam logic [4:0] BITS_PER_FRAME = 5'h10;

   // ****************************************************************
   // control word layout and reset value
   // ****************************************************************
   localparam int CTRL_WRITE_BIT = 11;
   localparam int CTRL_SEQ_BIT = 10;
   localparam int CTRL_ADDR_HI = 9;
   localparam int CTRL_ADDR_LO = 6;
   localparam int CTRL_PM_HI = 5;
   localparam int CTRL_PM_LO = 4;
   localparam int CTRL_SHADOW_BIT = 3;
   localparam int CTRL_WEAK_BIT = 2;
   localparam logic [11:0] CTRL_RESET = 12'h030;
   localparam logic [15:0] SHADOW_RESET = 16'h0000;
   localparam logic [11:0] RESULT_RESET = 12'h000;
   localparam logic [2:0] PIN_SYNC_RESET = 3'h7;

   // power_mode_hi/power_mode_lo codes
   localparam logic [1:0] PM_NORMAL = 2'h3;
   localparam logic [1:0] PM_FULL_DOWN = 2'h2;
   localparam logic [1:0] PM_AUTO_DOWN = 2'h1;
   localparam logic [1:0] PM_STANDBY = 2'h0;

   // ****************************************************************
   // register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_RESULT = 8'h08;
   localparam logic [7:0] ADDR_SHADOW = 8'h0c;

   typedef enum logic [2:0] {
      ASP_PWR_ON = 3'b000,
      ASP_PWR_FULL_DOWN = 3'b001,
      ASP_PWR_AUTO_DOWN = 3'b010,
      ASP_PWR_STANDBY = 3'b011,
      ASP_PWR_WAKING = 3'b100
   } asp_pwr_type;
endpackage : asp_pkg

// ### rtl/asp_link_if.sv
`timescale 1ns/100ps
// synchronised pin events passed from the pin stage to the controller
interface asp_link_if;
   logic sclk_fall;
   logic fs_fall;
   logic fs_rise;
   logic din;
   modport src (output sclk_fall, output fs_fall, output fs_rise, output din);
   modport dst (input sclk_fall, input fs_fall, input fs_rise, input din);
endinterface : asp_link_if

// ### rtl/asp_pin_sync.sv
`timescale 1ns/100ps
module asp_pin_sync
   import asp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic frame_sync_n,
   input wire logic conv_serial_clock,
   input wire logic config_serial_in,
   asp_link_if.src link
);
   // ****************************************************************
   // two-stage synchronisers plus one history stage
   // ****************************************************************
   logic [2:0] pin_raw;
   logic [2:0] meta_r;
   logic [2:0] sync_r;
   logic [2:0] prev_r;

   assign pin_raw = {frame_sync_n, conv_serial_clock, config_serial_in};

   // one synchroniser per pin; din takes the second stage, edges compare it with the history stage
   for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge clk) begin
         if (!rst_b) begin
            meta_r[i] <= PIN_SYNC_RESET[i];
            sync_r[i] <= PIN_SYNC_RESET[i];
            prev_r[i] <= PIN_SYNC_RESET[i];
         end else begin
            meta_r[i] <= pin_raw[i];
            sync_r[i] <= meta_r[i];
            prev_r[i] <= sync_r[i];
         end
      end
   end

   // ****************************************************************
   // registered edge events
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         link.sclk_fall <= 1'b0;
         link.fs_fall <= 1'b0;
         link.fs_rise <= 1'b0;
         link.din <= 1'b0;
      end else begin
         link.sclk_fall <= prev_r[1] & ~sync_r[1];
         link.fs_fall <= prev_r[2] & ~sync_r[2];
         link.fs_rise <= ~prev_r[2] & sync_r[2];
         link.din <= sync_r[0];
      end
   end
endmodule : asp_pin_sync

// ### rtl/asp_ctrl.sv
`timescale 1ns/100ps
// Functional notes
// - full shutdown powers down, holds until changed
// - normal write wakes on frame rise, tracks edge14
// - autoshutdown powers down after updated conversion
// - autoshutdown wakes on frame fall, back to track
// - autostandby keeps bias on after updated conversion
// - standby wakes on frame fall, dummy frame follows
// - auto modes start at end of conversion
// - serial clock drives conversion and all data
// - frame fall holds, samples, drives output, converts
// - track on edge 14, shadow frame at rise
// - output released on edge 16 unless weak
// - frame: four address bits then 12 result bits
// - top address bit from frame fall, then shifts
// - last bit launched edge 15, valid edge 16
// - first 12 bits load control when write set
// - normal mode stays powered between conversions
module asp_ctrl
   import asp_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic frame_sync_n,
   input wire logic conv_serial_clock,
   input wire logic config_serial_in,
   output logic result_serial_out,
   output logic result_serial_oe,
   output logic result_serial_weak,
   output logic track_mode,
   output logic conv_start,
   output logic core_power_on,
   output logic bias_power_on,
   output logic [3:0] chan_select,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   // ****************************************************************
   // state
   // ****************************************************************
   asp_link_if link ();
   asp_pwr_type pwr_r;
   asp_pwr_type pwr_nxt;
   logic [11:0] ctrl_r;
   logic [15:0] shadow_r;
   logic [11:0] result_data_r;
   logic [10:0] cfg_shift_r;
   logic [15:0] shadow_shift_r;
   logic [15:0] out_shift_r;
   logic [4:0] bit_cnt_r;
   logic [7:0] wake_cnt_r;
   logic [3:0] chan_cur_r;
   logic frame_active_r;
   logic ctrl_upd_r;
   logic shadow_pend_r;
   logic shadow_frame_r;
   logic track_r;
   logic track_nxt;

   asp_pin_sync u_pin_sync (
      .clk(clk),
      .rst_b(rst_b),
      .frame_sync_n(frame_sync_n),
      .conv_serial_clock(conv_serial_clock),
      .config_serial_in(config_serial_in),
      .link(link.src)
   );

   // ****************************************************************
   // frame decode
   // ****************************************************************
   logic sclk_edge;
   logic [4:0] edge_num;
   logic [11:0] cfg_word;
   logic [1:0] pm_cur;
   logic load_now;
   logic track_edge;
   logic eoc;
   logic frame_start;
   logic shadow_done;
   logic lowpower_req;

   // serial clock edges counted only inside a frame
   assign sclk_edge = link.sclk_fall & frame_active_r;
   assign edge_num = 5'(bit_cnt_r + 5'h01);
   assign cfg_word = {cfg_shift_r, link.din};
   assign pm_cur = ctrl_r[CTRL_PM_HI:CTRL_PM_LO];
   assign frame_start = link.fs_fall & ~frame_active_r;
   assign load_now = sclk_edge && edge_num == CFG_BITS && !shadow_frame_r
                     && cfg_word[CTRL_WRITE_BIT];
   assign track_edge = sclk_edge && edge_num == TRACK_EDGE && !shadow_frame_r
                       && !(pwr_r == ASP_PWR_FULL_DOWN && pm_cur == PM_FULL_DOWN);
   assign eoc = sclk_edge && edge_num == BITS_PER_FRAME;
   assign shadow_done = link.fs_rise && shadow_frame_r && bit_cnt_r == BITS_PER_FRAME;
   assign lowpower_req = eoc && ctrl_upd_r && pm_cur != PM_NORMAL;

   // frame window and edge counter
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         frame_active_r <= 1'b0;
         bit_cnt_r <= 5'h00;
      end else if (frame_start) begin
         frame_active_r <= 1'b1;
         bit_cnt_r <= 5'h00;
      end else begin
         frame_active_r <= frame_active_r & ~eoc & ~link.fs_rise;
         bit_cnt_r <= sclk_edge ? edge_num : bit_cnt_r;
      end
   end

   // ****************************************************************
   // control and shadow capture
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cfg_shift_r <= 11'h000;
         ctrl_r <= CTRL_RESET;
         ctrl_upd_r <= 1'b0;
      end else begin
         if (sclk_edge && bit_cnt_r < CFG_BITS) cfg_shift_r <= cfg_word[10:0];
         if (load_now) ctrl_r <= cfg_word;
         if (load_now) ctrl_upd_r <= 1'b1;
         else if (frame_start) ctrl_upd_r <= 1'b0;
      end
   end

   // shadow word captured on all 16 edges of the frame after a request
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         shadow_pend_r <= 1'b0;
         shadow_frame_r <= 1'b0;
         shadow_shift_r <= SHADOW_RESET;
         shadow_r <= SHADOW_RESET;
      end else begin
         if (load_now) begin
            shadow_pend_r <= ~cfg_word[CTRL_SEQ_BIT] & cfg_word[CTRL_SHADOW_BIT];
         end else if (frame_start) begin
            shadow_pend_r <= 1'b0;
         end
         if (frame_start) shadow_frame_r <= shadow_pend_r;
         else if (link.fs_rise) shadow_frame_r <= 1'b0;
         if (sclk_edge && shadow_frame_r) shadow_shift_r <= {shadow_shift_r[14:0], link.din};
         if (shadow_done) shadow_r <= shadow_shift_r;
      end
   end

   // ****************************************************************
   // serial output: address nibble then result, msb first
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         out_shift_r <= 16'h0000;
         result_serial_out <= 1'b0;
         result_serial_oe <= 1'b0;
         result_serial_weak <= 1'b0;
      end else if (frame_start) begin
         out_shift_r <= {chan_cur_r, result_data_r};
         result_serial_out <= chan_cur_r[3];
         result_serial_oe <= 1'b1;
         result_serial_weak <= 1'b0;
      end else if (eoc) begin
         result_serial_out <= chan_cur_r[3]; // next top address bit for weak hold
         result_serial_oe <= 1'b0;
         result_serial_weak <= ctrl_r[CTRL_WEAK_BIT];
      end else if (sclk_edge) begin
         out_shift_r <= {out_shift_r[14:0], 1'b0};
         result_serial_out <= out_shift_r[14];
      end else if (link.fs_rise && frame_active_r) begin
         result_serial_oe <= 1'b0; // aborted frame releases the line
      end
   end

   // channel mux moves to the programmed channel on edge 14
   always_ff @(posedge clk) begin
      if (!rst_b) chan_cur_r <= CTRL_RESET[CTRL_ADDR_HI:CTRL_ADDR_LO];
      else if (sclk_edge && edge_num == TRACK_EDGE) chan_cur_r <= ctrl_r[CTRL_ADDR_HI:CTRL_ADDR_LO];
   end

   // ****************************************************************
   // power state
   // ****************************************************************
   function automatic asp_pwr_type lp_state(input logic [1:0] pm);
      case (pm)
         PM_FULL_DOWN: lp_state = ASP_PWR_FULL_DOWN;
         PM_AUTO_DOWN: lp_state = ASP_PWR_AUTO_DOWN;
         PM_STANDBY: lp_state = ASP_PWR_STANDBY;
         default: lp_state = ASP_PWR_ON;
      endcase
   endfunction : lp_state

   always_comb begin
      pwr_nxt = pwr_r;
      case (pwr_r)
         ASP_PWR_ON: begin
            if (lowpower_req) pwr_nxt = lp_state(pm_cur);
         end
         ASP_PWR_FULL_DOWN: begin
            if (lowpower_req && pm_cur != PM_FULL_DOWN) pwr_nxt = lp_state(pm_cur);
            else if (link.fs_rise && pm_cur == PM_NORMAL) pwr_nxt = ASP_PWR_WAKING;
         end
         ASP_PWR_AUTO_DOWN, ASP_PWR_STANDBY: begin
            if (link.fs_fall) pwr_nxt = ASP_PWR_WAKING;
         end
         ASP_PWR_WAKING: begin
            if (lowpower_req) pwr_nxt = lp_state(pm_cur);
            else if (wake_cnt_r <= 8'h01) pwr_nxt = ASP_PWR_ON;
         end
         default: pwr_nxt = ASP_PWR_ON;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) pwr_r <= ASP_PWR_ON;
      else pwr_r <= pwr_nxt;
   end

   // wake timer: power-up wait from full shutdown, wake time otherwise
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wake_cnt_r <= 8'h00;
      end else if (pwr_nxt == ASP_PWR_WAKING && pwr_r != ASP_PWR_WAKING) begin
         wake_cnt_r <= (pwr_r == ASP_PWR_FULL_DOWN) ? POWER_UP_WAIT_CYC : WAKE_CYC;
      end else if (wake_cnt_r != 8'h00) begin
         wake_cnt_r <= 8'(wake_cnt_r - 8'h01);
      end
   end

   // track-and-hold: later items take priority
   always_comb begin
      track_nxt = track_r;
      if (frame_start) begin
         track_nxt = (pwr_r == ASP_PWR_AUTO_DOWN || pwr_r == ASP_PWR_STANDBY);
      end
      if (track_edge) track_nxt = 1'b1;
      if (shadow_done) track_nxt = 1'b1;
      if (lowpower_req) track_nxt = 1'b0;
   end

   // power and track outputs follow the next state
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         track_r <= 1'b1;
         core_power_on <= 1'b1;
         bias_power_on <= 1'b1;
         conv_start <= 1'b0;
      end else begin
         track_r <= track_nxt;
         core_power_on <= (pwr_nxt == ASP_PWR_ON || pwr_nxt == ASP_PWR_WAKING);
         bias_power_on <= (pwr_nxt != ASP_PWR_FULL_DOWN && pwr_nxt != ASP_PWR_AUTO_DOWN);
         conv_start <= frame_start && pwr_r == ASP_PWR_ON;
      end
   end

   assign track_mode = track_r;
   assign chan_select = chan_cur_r;

   // ****************************************************************
   // apb slave, zero wait states
   // ****************************************************************
   logic apb_setup;
   logic apb_wr;
   logic addr_hit;
   logic [31:0] rd_mux;
   logic [31:0] status_word;

   assign apb_setup = psel & ~penable;
   assign apb_wr = psel & penable & pready & pwrite;
   assign addr_hit = paddr == ADDR_CTRL || paddr == ADDR_STATUS
                     || paddr == ADDR_RESULT || paddr == ADDR_SHADOW;
   assign status_word = {20'h0_0000, wake_cnt_r[3:0] != 4'h0, shadow_frame_r, shadow_pend_r,
                         ctrl_upd_r, frame_active_r, track_r, core_power_on,
                         bias_power_on, 1'b0, pwr_r};
   assign rd_mux = (paddr == ADDR_CTRL) ? {20'h0_0000, ctrl_r} :
                   (paddr == ADDR_STATUS) ? status_word :
                   (paddr == ADDR_RESULT) ? {20'h0_0000, result_data_r} :
                   (paddr == ADDR_SHADOW) ? {16'h0000, shadow_r} : 32'h0000_0000;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= apb_setup;
         pslverr <= apb_setup & ~addr_hit;
         prdata <= apb_setup ? rd_mux : 32'h0000_0000;
      end
   end

   // result value returned in the next frame
   always_ff @(posedge clk) begin
      if (!rst_b) result_data_r <= RESULT_RESET;
      else if (apb_wr && paddr == ADDR_RESULT) result_data_r <= pwdata[11:0];
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   AST_OE_ON_FS: assert property (frame_start |=> result_serial_oe && !result_serial_weak)
      else $error("output not driven after frame start");
   AST_HOLD_ON_FS: assert property (frame_start && pwr_r == ASP_PWR_ON |=> !track_r)
      else $error("track-and-hold not in hold at frame start");
   AST_FIRST_BIT: assert property (frame_start |=> result_serial_out == $past(chan_cur_r[3]))
      else $error("top address bit not presented at frame start");
   AST_SHIFT: assert property (sclk_edge && !eoc |=> result_serial_out == $past(out_shift_r[14]))
      else $error("serial bit not launched from shift");
   AST_TRACK_14: assert property (track_edge && !lowpower_req |=> track_r)
      else $error("no return to track on edge 14");
   AST_RELEASE_16: assert property (eoc |=> !result_serial_oe ##1 !result_serial_oe)
      else $error("output not released on edge 16");
   AST_CTRL_HOLD: assert property (!load_now |=> $stable(ctrl_r))
      else $error("control changed outside a write");
   AST_FULL_STAY: assert property (pwr_r == ASP_PWR_FULL_DOWN && pm_cur == PM_FULL_DOWN
                                   |=> pwr_r == ASP_PWR_FULL_DOWN && !core_power_on)
      else $error("left full shutdown without a mode change");
   AST_PWRUP_RISE: assert property (pwr_r == ASP_PWR_FULL_DOWN && link.fs_rise
                                    && pm_cur == PM_NORMAL |=> pwr_r == ASP_PWR_WAKING)
      else $error("no power-up on frame rise");
   AST_AUTO_DOWN: assert property (lowpower_req && pm_cur == PM_AUTO_DOWN && pwr_r == ASP_PWR_ON
                                   |=> pwr_r == ASP_PWR_AUTO_DOWN && !track_r)
      else $error("autoshutdown not entered");
   AST_WAKE_FS: assert property ((pwr_r == ASP_PWR_AUTO_DOWN || pwr_r == ASP_PWR_STANDBY)
                                 && link.fs_fall |=> pwr_r == ASP_PWR_WAKING && track_r)
      else $error("no wake on frame fall");
   AST_STANDBY_BIAS: assert property (lowpower_req && pm_cur == PM_STANDBY && pwr_r == ASP_PWR_ON
                                      |=> pwr_r == ASP_PWR_STANDBY ##1 bias_power_on)
      else $error("standby lost bias");
   AST_NO_EARLY: assert property (load_now && pwr_r == ASP_PWR_ON |=> pwr_r == ASP_PWR_ON [*3])
      else $error("mode change before end of conversion");
   AST_NORMAL_STAY: assert property (pwr_r == ASP_PWR_ON && pm_cur == PM_NORMAL
                                     |=> pwr_r == ASP_PWR_ON)
      else $error("normal mode powered down");
   AST_WAKE_TIME: assert property ($rose(pwr_r == ASP_PWR_WAKING) && !lowpower_req
                                   |-> ##[1:110] pwr_r != ASP_PWR_WAKING)
      else $error("wake took too long");

   COV_FRAME: cover property (frame_start ##[1:400] eoc);
   COV_WRITE: cover property (load_now ##[1:200] eoc);
   COV_AUTO: cover property (pwr_r == ASP_PWR_AUTO_DOWN ##[1:600] pwr_r == ASP_PWR_ON);
   COV_SHADOW: cover property (shadow_done);
endmodule : asp_ctrl

// ### tb/asp_host_model.sv
`timescale 1ns/100ps
// host serial port: frame sync, serial clock, config bits, result capture
module asp_host_model (
   input wire logic clk,
   output logic frame_sync_n,
   output logic conv_serial_clock,
   output logic config_serial_in,
   input wire logic result_serial_out
);
   // pins idle high; the serial clock stands still between frames
   initial begin
      frame_sync_n = 1'b1;
      conv_serial_clock = 1'b1;
      config_serial_in = 1'b1;
   end

   // one frame of 16 falling edges, 160 ns serial period
   task automatic frame(input logic [15:0] cfg, output logic [15:0] rd);
      rd = 16'h0000;
      @(posedge clk);
      frame_sync_n <= 1'b0;
      config_serial_in <= cfg[15];
      repeat (8) @(posedge clk);
      for (int i = 0; i < 16; i++) begin
         @(negedge clk);
         rd = {rd[14:0], result_serial_out};
         @(posedge clk);
         conv_serial_clock <= 1'b0;
         repeat (8) @(posedge clk);
         conv_serial_clock <= 1'b1;
         config_serial_in <= (i < 15) ? cfg[14 - i] : 1'b1;
         repeat (7) @(posedge clk);
      end
      frame_sync_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask : frame
endmodule : asp_host_model

// ### tb/testbench.sv
`timescale 1ns/100ps
module testbench
   import asp_pkg::*;
;
   typedef struct packed {
      logic [11:0] cfg;
      logic [11:0] res;
      logic [15:0] frm;
      logic [3:0] ch;
   } asp_row_type;
   logic clk, rst_b, frame_sync_n, conv_serial_clock, config_serial_in, result_serial_out;
   logic serial_line;
   logic result_serial_oe, result_serial_weak, track_mode, conv_start, core_power_on;
   logic bias_power_on, psel, penable, pwrite, pready, pslverr, err;
   logic [3:0] chan_select;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [15:0] frm;
   logic [11:0] ctl;
   logic [1:0] pm_list [3] = '{PM_STANDBY, PM_AUTO_DOWN, PM_FULL_DOWN};
   int miscompares = 0;
   int n_checks = 0;
   int n_conv = 0;
   int conv_seen;
   // ordinary frames: config, result, expected frame word, expected channel
   asp_row_type rows [5] = '{'{12'h970, 12'h5a5, 16'hf5a5, 4'h5},
      '{12'hab0, 12'h0c3, 16'h50c3, 4'ha}, '{12'h3f0, 12'h001, 16'ha001, 4'ha},
      '{12'h830, 12'h800, 16'ha800, 4'h0}, '{12'h8f0, 12'hfff, 16'h0fff, 4'h3}};

   asp_ctrl dut (.clk(clk), .rst_b(rst_b), .frame_sync_n(frame_sync_n),
      .conv_serial_clock(conv_serial_clock), .config_serial_in(config_serial_in),
      .result_serial_out(result_serial_out), .result_serial_oe(result_serial_oe),
      .result_serial_weak(result_serial_weak), .track_mode(track_mode),
      .conv_start(conv_start), .core_power_on(core_power_on),
      .bias_power_on(bias_power_on), .chan_select(chan_select), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   asp_host_model host (.clk(clk), .frame_sync_n(frame_sync_n),
      .conv_serial_clock(conv_serial_clock), .config_serial_in(config_serial_in),
      .result_serial_out(serial_line));

   // a released line shows the inverse of the last bit, so a late or missing drive is seen
   assign serial_line = (result_serial_oe || result_serial_weak) ? result_serial_out
                        : ~result_serial_out;

   // counts conversion start pulses
   always @(posedge clk) begin
      if (conv_start === 1'b1) n_conv <= n_conv + 1;
   end

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim

   // one apb transfer; holds the request until pready is sampled high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         miscompares++;
         end_sim();
      end
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      miscompares++;
      end_sim();
   end

   // main sequence
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chk("oe", 32'h0000_0000, 32'(result_serial_oe));
      chk("track", 32'h0000_0001, 32'(track_mode));
      chk("core", 32'h0000_0001, 32'(core_power_on));
      apb(1'b0, ADDR_CTRL, 32'h0000_0000);
      chk("ctrl", 32'(CTRL_RESET), rdata);
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk("slverr", 32'h0000_0001, 32'(err));
      apb(1'b1, ADDR_CTRL, 32'h0000_0fff);
      apb(1'b0, ADDR_CTRL, 32'h0000_0000);
      chk("ctrl ro", 32'(CTRL_RESET), rdata);
      $display("test reset done");
      repeat (2) host.frame(16'hffff, frm);
      ctl = 12'hfff;
      foreach (rows[i]) begin
         apb(1'b1, ADDR_RESULT, 32'(rows[i].res));
         conv_seen = n_conv;
         host.frame({rows[i].cfg, 4'h0}, frm);
         chk("frame", 32'(rows[i].frm), 32'(frm));
         chk("conv", 32'(conv_seen + 1), 32'(n_conv));
         if (rows[i].cfg[11]) begin
            ctl = rows[i].cfg;
         end
         apb(1'b0, ADDR_CTRL, 32'h0000_0000);
         chk("ctrl", 32'(ctl[10:0]), 32'(rdata[10:0]));
         chk("chan", 32'(rows[i].ch), 32'(chan_select));
         chk("oe", 32'h0000_0000, 32'(result_serial_oe));
         chk("track", 32'h0000_0001, 32'(track_mode));
         chk("core", 32'h0000_0001, 32'(core_power_on));
      end
      $display("test frames done");
      host.frame(16'h8f40, frm);
      chk("weak", 32'h0000_0001, 32'(result_serial_weak));
      host.frame(16'h8f00, frm);
      chk("weak", 32'h0000_0000, 32'(result_serial_weak));
      $display("test weak done");
      // shadow request well after power-on, then a 16-bit shadow frame
      host.frame(16'h8f80, frm);
      host.frame(16'h1234, frm);
      chk("track", 32'h0000_0001, 32'(track_mode));
      apb(1'b0, ADDR_SHADOW, 32'h0000_0000);
      chk("shadow", 32'h0000_1234, rdata);
      apb(1'b0, ADDR_CTRL, 32'h0000_0000);
      chk("ctrl", 32'h0000_08f8, rdata);
      $display("test shadow done");
      // low-power modes, each entered, sent a dummy frame that wakes all but full shutdown, then left
      foreach (pm_list[m]) begin
         host.frame({4'h8, 2'h3, pm_list[m], 8'h00}, frm);
         chk("core", 32'h0000_0000, 32'(core_power_on));
         chk("bias", 32'(pm_list[m] == PM_STANDBY), 32'(bias_power_on));
         chk("track", 32'h0000_0000, 32'(track_mode));
         host.frame(16'h0000, frm);
         repeat (WAKE_CYC) @(posedge clk);
         chk("wake", 32'(pm_list[m] != PM_FULL_DOWN), 32'(core_power_on));
         host.frame(16'h8f00, frm);
         repeat (POWER_UP_WAIT_CYC) @(posedge clk);
         chk("core", 32'h0000_0001, 32'(core_power_on));
         chk("track", 32'h0000_0001, 32'(track_mode));
         $display("test mode %0d done", m);
      end
      // second reset mid-run, one high frame only, then normal configuration
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chk("oe", 32'h0000_0000, 32'(result_serial_oe));
      chk("chan", 32'h0000_0000, 32'(chan_select));
      host.frame(16'hffff, frm);
      host.frame(16'h8f00, frm);
      chk("frame", 32'h0000_f000, 32'(frm));
      apb(1'b0, ADDR_CTRL, 32'h0000_0000);
      chk("ctrl", 32'h0000_08f0, rdata);
      chk("core", 32'h0000_0001, 32'(core_power_on));
      $display("test mid reset done");
      end_sim();
   end
endmodule : testbench
